// *** core/fpgate_pkg.sv ***
// Purpose: Shared constants and carriers for the FP/SIMD fault gating core
// Assumes: 32-bit register port, 64-bit operand path
// Notes:   Offsets are word indices on the plain register port
package fpgate_pkg;

  // Register port offsets
  localparam logic [3:0] OFS_CTRL0  = 4'h0;  // control_reg_zero
  localparam logic [3:0] OFS_CTRL4  = 4'h1;  // control_reg_four
  localparam logic [3:0] OFS_FLAGS  = 4'h2;  // processor_flags_reg
  localparam logic [3:0] OFS_TBASE  = 4'h3;  // table_base_pointer_reg
  localparam logic [3:0] OFS_VTP    = 4'h4;  // vector_table_pointer
  localparam logic [3:0] OFS_GDP    = 4'h5;  // global_descriptor_pointer
  localparam logic [3:0] OFS_MXCTL  = 4'h6;  // simd_fp_control_status
  localparam logic [3:0] OFS_STATUS = 4'h7;  // read-only core status

  // control_reg_zero bit positions
  localparam int PE_BIT = 0;   // protection_on_bit
  localparam int MP_BIT = 1;   // monitor_coprocessor_bit
  localparam int EM_BIT = 2;   // fpu_trap_all_bit
  localparam int TS_BIT = 3;   // task_switched_flag
  localparam int NE_BIT = 5;   // native_fp_error_bit
  localparam int PG_BIT = 31;  // translation_on_bit
  // control_reg_four bit positions
  localparam int OSVS_BIT = 9;   // os_saves_vector_state
  localparam int OSXF_BIT = 10;  // os_handles_simd_fp_faults
  // processor_flags_reg bit position
  localparam int IRQ_ALLOW_BIT = 9;  // maskable_irq_allow
  // simd_fp_control_status: flags in 5:0, masks in 12:7
  localparam int MX_FLAG_LSB = 0;
  localparam int MX_MASK_LSB = 7;
  localparam int MX_EXC_W    = 6;

  // Writable bit masks and reset values
  localparam logic [31:0] CTRL0_WMASK = 32'h8000_002f;
  localparam logic [31:0] CTRL4_WMASK = 32'h0000_0600;
  localparam logic [31:0] FLAGS_WMASK = 32'h0000_0200;
  localparam logic [31:0] MXCTL_WMASK = 32'h0000_1fbf;
  localparam logic [31:0] CTRL0_RST   = 32'h0000_0000;
  localparam logic [31:0] CTRL4_RST   = 32'h0000_0000;
  localparam logic [31:0] FLAGS_RST   = 32'h0000_0002;
  localparam logic [31:0] MXCTL_RST   = 32'h0000_1f80;
  localparam logic [63:0] MEDIA_RST   = 64'h0000_0000_0000_0000;
  localparam logic [15:0] X87_RST     = 16'h0000;

  // Instruction classes seen at decode
  typedef enum logic [3:0] {
    CLS_NONE, CLS_X87, CLS_FP_SYNC, CLS_FP_CLEAR, CLS_MEDIA, CLS_SIMD,
    CLS_VEC_SAVE, CLS_VEC_RESTORE, CLS_MODEL_RD, CLS_MODEL_WR
  } instr_cls_t;

  // Fault outcome
  typedef enum logic [2:0] {
    FLT_NONE, FLT_DEV_UNAVAIL, FLT_INVALID_OP, FLT_FP_PENDING, FLT_SIMD_FP
  } fault_t;

  // Decoded instruction
  typedef struct packed {
    logic                valid;
    instr_cls_t          cls;
    logic [MX_EXC_W-1:0] exc;    // raised FP exception flags
    logic [3:0]          index;  // model register index
    logic [63:0]         data;   // operand
  } instr_t;

  // Retire result
  typedef struct packed {
    logic        valid;
    fault_t      fault;
    logic [63:0] data;
  } result_t;

endpackage

// *** core/fault_select.sv ***
// Purpose: Chooses the fault for one decoded instruction
// Assumes: Control words are the committed values of this cycle
// Notes:   Pure combinational; the caller registers the answer
`timescale 1ns/10ps
`default_nettype none
module fault_select import fpgate_pkg::*; (
  input  wire logic [31:0] ctrl0,
  input  wire logic [31:0] ctrl4,
  input  wire logic [31:0] mxctl,
  input  wire instr_t      instr,
  output var  fault_t      fault
);

  // Unmasked exceptions among those raised
  logic [MX_EXC_W-1:0] unmasked;  // Raised and not masked
  assign unmasked = instr.exc & ~mxctl[MX_MASK_LSB +: MX_EXC_W];

  // Priority per class
  always_comb begin
    fault = FLT_NONE;
    case (instr.cls)
      // [RULE1] wait with lazy switch
      CLS_FP_SYNC: begin
        if (ctrl0[MP_BIT] && ctrl0[TS_BIT]) fault = FLT_DEV_UNAVAIL;
      end
      CLS_X87: begin
        // [RULE2] trap all x87
        if (ctrl0[EM_BIT]) fault = FLT_DEV_UNAVAIL;
        // [RULE3] native error report
        else if (|unmasked && ctrl0[NE_BIT]) fault = FLT_FP_PENDING;
      end
      // [RULE5] media blocked by trap
      CLS_MEDIA: begin
        if (ctrl0[EM_BIT]) fault = FLT_INVALID_OP;
      end
      CLS_SIMD: begin
        // [RULE8] simd blocked by trap
        if (ctrl0[EM_BIT]) fault = FLT_INVALID_OP;
        // [RULE10] needs vector save enable
        else if (!ctrl4[OSVS_BIT]) fault = FLT_INVALID_OP;
        // [RULE12] simd fault delivery
        else if (|unmasked) begin
          fault = ctrl4[OSXF_BIT] ? FLT_SIMD_FP : FLT_INVALID_OP;
        end
      end
      // [RULE9] save/restore gets device fault
      CLS_VEC_SAVE, CLS_VEC_RESTORE: begin
        if (ctrl0[EM_BIT]) fault = FLT_DEV_UNAVAIL;
      end
      default: fault = FLT_NONE;
    endcase
  end

endmodule
`default_nettype wire

// *** core/model_reg_bank.sv ***
// Purpose: Model-specific register storage
// Assumes: Only the instruction path reaches it
// Notes:   Contents are not reset; a written flag hides stale data
`timescale 1ns/10ps
`default_nettype none
module model_reg_bank import fpgate_pkg::*; #(
  parameter int REGS = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        wr,
  input  wire logic [3:0]  index,
  input  wire logic [63:0] wdata,
  output logic      [63:0] rdata
);

  // Refuse sizes the 4-bit index cannot serve
  initial begin
    if (REGS < 1 || REGS > 16) $error("model_reg_bank: REGS out of range");
  end

  // Storage and written flags
  logic [REGS-1:0][63:0] mem_reg;      // Unreset contents
  logic [REGS-1:0]       written_reg;  // Set once configured
  logic                  hit;          // Index in range
  assign hit = 32'(index) < REGS;

  // [RULE15] contents left unset
  always_ff @(posedge clk) begin
    if (ce && wr && hit) mem_reg[index] <= wdata;
  end

  // Written flags need a defined start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      written_reg <= '0;
    end else if (ce && wr && hit) begin
      written_reg[index] <= 1'b1;
    end
  end

  // Unconfigured or absent entries read zero
  assign rdata = (hit && written_reg[index]) ? mem_reg[index] : 64'h0;

endmodule
`default_nettype wire

// *** core/fpgate_core.sv ***
// Purpose: Control-bit gating of FP, media and SIMD instructions plus
//          startup mode enables and interrupt acceptance
// Assumes: One clock; inputs synchronous; init is a one-cycle pulse
// Notes:   Control registers live on the plain register port; model
//          registers only on the instruction path
//
// Notes on behaviour
// [RULE1] Wait with monitor and switched: device fault
// [RULE2] Trap-all bit makes x87 device fault
// [RULE3] Native error: unmasked x87 gives pending fault
// [RULE4] Otherwise raise external error indication pin
// [RULE5] Trap-all bit makes media invalid opcode
// [RULE6] Reset clears all media state
// [RULE7] INIT keeps media state
// [RULE8] Trap-all makes SIMD invalid, except save/restore
// [RULE9] Save/restore under trap-all: device fault
// [RULE10] SIMD needs vector save enable bit
// [RULE11] Save/restore carries SIMD, media, x87 state
// [RULE12] Handler bit routes SIMD faults to SIMD fault
// [RULE13] SIMD mask bits software read/write
// [RULE14] Model registers only via model ops
// [RULE15] Model registers not reset
// [RULE16] Unmaskable interrupt always accepted
// [RULE17] System logic blocks unmaskable interrupt early
// [RULE18] Maskable interrupts need allow flag
// [RULE19] Pointers loaded, then protection bit enters
// [RULE20] Translation only once protected
// [RULE21] Walk starts from table base register
// [RULE22] Software enters protected before long mode
// [RULE23] Faults use committed bits at decode
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module fpgate_core import fpgate_pkg::*; #(
  parameter int MODEL_REGS = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        init,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire instr_t      instr,
  output result_t          result,
  output logic             fp_error_ext,
  input  wire logic        irq_req,
  input  wire logic        nmi_req,
  output logic             irq_take,
  output logic             nmi_take,
  output logic             protected_on,
  output logic             paging_on,
  output logic      [31:0] walk_base
);

  // Refuse model bank sizes the index cannot reach
  initial begin
    if (MODEL_REGS < 1 || MODEL_REGS > 16) begin
      $error("fpgate_core: MODEL_REGS out of range");
    end
  end

  // Whole core state
  typedef struct packed {
    logic [31:0] ctrl0;      // control_reg_zero
    logic [31:0] ctrl4;      // control_reg_four
    logic [31:0] flags;      // processor_flags_reg
    logic [31:0] tbase;      // table_base_pointer_reg
    logic [31:0] vtp;        // vector_table_pointer
    logic [31:0] gdp;        // global_descriptor_pointer
    logic [31:0] mxctl;      // simd_fp_control_status
    logic        vtp_ld;     // Vector table pointer loaded
    logic        gdp_ld;     // Descriptor pointer loaded
    logic [63:0] media;      // 64-bit media state
    logic [63:0] simd;       // SIMD register state
    logic [15:0] x87;        // x87 status state
    logic [63:0] img_media;  // Saved image
    logic [63:0] img_simd;
    logic [15:0] img_x87;
    logic [31:0] img_mxctl;
    logic        ferr;       // External error indication
    result_t     res;        // Retire result
    logic [31:0] rdata;      // Register read data
    logic        irq_take;   // Maskable accept pulse
    logic        nmi_take;   // Unmaskable accept pulse
  } state_t;

  state_t      st_reg;     // Registered state
  state_t      st_next;    // Next state
  fault_t      fault;      // Fault for current instruction
  logic [63:0] model_rd;   // Model bank read data
  logic        model_wr;   // Model bank write strobe
  logic        ok;         // Instruction retires without fault

  // Merge helper for masked writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction

  // [RULE23] committed bits at decode
  fault_select u_fault (
    .ctrl0 (st_reg.ctrl0),
    .ctrl4 (st_reg.ctrl4),
    .mxctl (st_reg.mxctl),
    .instr (instr),
    .fault (fault)
  );

  assign ok       = instr.valid && (fault == FLT_NONE);
  // [RULE14] only model write op reaches bank
  assign model_wr = ok && (instr.cls == CLS_MODEL_WR);

  // Model bank, kept off the register port on purpose
  model_reg_bank #(
    .REGS (MODEL_REGS)
  ) u_model (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .wr    (model_wr),
    .index (instr.index),
    .wdata (instr.data),
    .rdata (model_rd)
  );

  // Next-state logic
  always_comb begin
    logic [31:0] c0;  // Candidate control word
    c0      = 32'h0;
    st_next = st_reg;
    st_next.irq_take  = 1'b0;
    st_next.nmi_take  = 1'b0;
    st_next.res.valid = 1'b0;
    st_next.rdata     = 32'h0;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL0: begin
          c0 = merge(st_reg.ctrl0, reg_wdata, CTRL0_WMASK);
          // [RULE19] protection needs both pointers
          if (!st_reg.ctrl0[PE_BIT] && !(st_reg.vtp_ld && st_reg.gdp_ld)) begin
            c0[PE_BIT] = 1'b0;
          end
          // [RULE20] translation only when protected
          if (!c0[PE_BIT]) c0[PG_BIT] = 1'b0;
          st_next.ctrl0 = c0;
        end
        OFS_CTRL4: st_next.ctrl4 = merge(st_reg.ctrl4, reg_wdata, CTRL4_WMASK);
        OFS_FLAGS: st_next.flags = merge(st_reg.flags, reg_wdata, FLAGS_WMASK);
        OFS_TBASE: st_next.tbase = reg_wdata;
        OFS_VTP: begin
          st_next.vtp    = reg_wdata;
          st_next.vtp_ld = 1'b1;
        end
        OFS_GDP: begin
          st_next.gdp    = reg_wdata;
          st_next.gdp_ld = 1'b1;
        end
        // [RULE13] masks writable by software
        OFS_MXCTL: st_next.mxctl = merge(st_reg.mxctl, reg_wdata, MXCTL_WMASK);
        default: ;  // Unmapped or read-only: ignored
      endcase
    end

    // Register reads, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL0:  st_next.rdata = st_reg.ctrl0;
        OFS_CTRL4:  st_next.rdata = st_reg.ctrl4;
        OFS_FLAGS:  st_next.rdata = st_reg.flags;
        OFS_TBASE:  st_next.rdata = st_reg.tbase;
        OFS_VTP:    st_next.rdata = st_reg.vtp;
        OFS_GDP:    st_next.rdata = st_reg.gdp;
        OFS_MXCTL:  st_next.rdata = st_reg.mxctl;
        OFS_STATUS: st_next.rdata = {28'h0, st_reg.ferr, st_reg.gdp_ld,
                                     st_reg.vtp_ld, st_reg.ctrl0[PE_BIT]};
        default:    st_next.rdata = 32'h0;
      endcase
    end

    // Instruction retire
    if (instr.valid) begin
      st_next.res.valid = 1'b1;
      st_next.res.fault = fault;
      st_next.res.data  = 64'h0;
      if (ok) begin
        case (instr.cls)
          CLS_X87: begin
            st_next.x87 = instr.data[15:0];
            // [RULE4] external error indication
            if (|(instr.exc & ~st_reg.mxctl[MX_MASK_LSB +: MX_EXC_W])) begin
              st_next.ferr = 1'b1;
            end
          end
          // Clears the pin; exception flags raised by this op are ignored
          CLS_FP_CLEAR: st_next.ferr = 1'b0;
          CLS_MEDIA: st_next.media = instr.data;
          CLS_SIMD: begin
            st_next.simd = instr.data;
            // Sticky flags, set on top of the old ones
            st_next.mxctl[MX_FLAG_LSB +: MX_EXC_W] =
              st_reg.mxctl[MX_FLAG_LSB +: MX_EXC_W] | instr.exc;
          end
          // [RULE11] save all three states
          CLS_VEC_SAVE: begin
            st_next.img_media = st_reg.media;
            st_next.img_simd  = st_reg.simd;
            st_next.img_x87   = st_reg.x87;
            st_next.img_mxctl = st_reg.mxctl;
          end
          // [RULE11] restore all three states
          CLS_VEC_RESTORE: begin
            st_next.media = st_reg.img_media;
            st_next.simd  = st_reg.img_simd;
            st_next.x87   = st_reg.img_x87;
            st_next.mxctl = st_reg.img_mxctl;
          end
          // [RULE14] model read op
          CLS_MODEL_RD: st_next.res.data = model_rd;
          default: ;
        endcase
      end else if (fault == FLT_FP_PENDING || fault == FLT_SIMD_FP) begin
        // Record raised SIMD flags on a SIMD FP fault too, not on invalid opcode
        if (instr.cls == CLS_SIMD) begin
          st_next.mxctl[MX_FLAG_LSB +: MX_EXC_W] =
            st_reg.mxctl[MX_FLAG_LSB +: MX_EXC_W] | instr.exc;
        end
      end
    end

    // [RULE16] unmaskable always taken
    st_next.nmi_take = nmi_req;
    // [RULE18] maskable needs allow flag
    st_next.irq_take = irq_req && st_reg.flags[IRQ_ALLOW_BIT];

    // [RULE7] INIT resets control, keeps media and FP state
    if (init) begin
      st_next.ctrl0  = CTRL0_RST;
      st_next.ctrl4  = CTRL4_RST;
      st_next.flags  = FLAGS_RST;
      st_next.tbase  = 32'h0;
      st_next.vtp_ld = 1'b0;
      st_next.gdp_ld = 1'b0;
      st_next.ferr   = 1'b0;
      st_next.irq_take = 1'b0;
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg       <= '0;
      st_reg.ctrl0 <= CTRL0_RST;
      st_reg.ctrl4 <= CTRL4_RST;
      st_reg.flags <= FLAGS_RST;
      st_reg.mxctl <= MXCTL_RST;
      // [RULE6] media state fully cleared
      st_reg.media <= MEDIA_RST;
      st_reg.x87   <= X87_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from state
  assign reg_rdata    = st_reg.rdata;
  assign result       = st_reg.res;
  assign fp_error_ext = st_reg.ferr;
  assign irq_take     = st_reg.irq_take;
  assign nmi_take     = st_reg.nmi_take;
  assign protected_on = st_reg.ctrl0[PE_BIT];
  assign paging_on    = st_reg.ctrl0[PG_BIT];
  // [RULE21] walk base from table base
  assign walk_base    = st_reg.tbase;

endmodule
`default_nettype wire

// *** tb/fpgate_core_properties.sv ***
// Purpose: Port-level checks on the FP/SIMD fault gating core
// Assumes: One clock domain, rst_b asynchronous and active low
// Notes:   Shadows the trap-all bit from register writes, so gating
//          is judged against the committed value at decode
`timescale 1ns/10ps
`default_nettype none
module fpgate_core_properties import fpgate_pkg::*; #(
  parameter int MODEL_REGS = 16
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic        init,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire instr_t      instr,
  input wire result_t     result,
  input wire logic        fp_error_ext,
  input wire logic        irq_req,
  input wire logic        nmi_req,
  input wire logic        irq_take,
  input wire logic        nmi_take,
  input wire logic        protected_on,
  input wire logic        paging_on,
  input wire logic [31:0] walk_base
);
  logic em_reg;   // Trap-all bit as committed
  logic em_next;  // Its next value

  // Init wins; the bench never writes in an init cycle
  always_comb begin
    em_next = em_reg;
    if (ce && init) begin
      em_next = 1'b0;
    end else if (ce && reg_wr && reg_addr == OFS_CTRL0) begin
      em_next = reg_wdata[EM_BIT];
    end
  end

  // Registered, so a write reaches only later instructions
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      em_reg <= 1'b0;
    end else begin
      em_reg <= em_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  res_pulse_a: assert property (ce && instr.valid |=> result.valid)
    else $error("result pulse missing after instruction");
  res_idle_a: assert property (ce && !instr.valid |=> !result.valid)
    else $error("result pulse without instruction");
  trap_media_a: assert property (ce && instr.valid && em_reg &&
    instr.cls inside {CLS_MEDIA, CLS_SIMD} |=> result.fault == FLT_INVALID_OP)
    else $error("media or simd not refused under trap-all");
  trap_x87_a: assert property (ce && instr.valid && em_reg &&
    instr.cls == CLS_X87 |=> result.fault == FLT_DEV_UNAVAIL)
    else $error("x87 not refused under trap-all");
  trap_save_a: assert property (ce && instr.valid && em_reg &&
    instr.cls inside {CLS_VEC_SAVE, CLS_VEC_RESTORE}
    |=> result.fault == FLT_DEV_UNAVAIL)
    else $error("save or restore not refused under trap-all");
  nmi_follow_a: assert property (ce |=> nmi_take == $past(nmi_req))
    else $error("unmaskable request not taken");
  irq_gate_a: assert property (ce && !irq_req |=> !irq_take)
    else $error("maskable take without request");
  page_prot_a: assert property (paging_on |-> protected_on)
    else $error("translation on outside protected mode");
  base_load_a: assert property (ce && reg_wr && !init &&
    reg_addr == OFS_TBASE |=> walk_base == $past(reg_wdata))
    else $error("walk base not loaded");
  init_clear_a: assert property (ce && init |=>
    !protected_on && !paging_on && walk_base == 32'h0)
    else $error("mode bits kept over init");
  data_zero_a: assert property (ce && instr.valid &&
    instr.cls != CLS_MODEL_RD |=> result.data == 64'h0)
    else $error("result data without model read");

  // Main scenarios reached
  dev_seen_c: cover property (result.valid && result.fault == FLT_DEV_UNAVAIL);
  page_seen_c: cover property ($rose(paging_on));
  take_seen_c: cover property (irq_take && nmi_take);
endmodule

bind fpgate_core fpgate_core_properties #(.MODEL_REGS(MODEL_REGS)) props (
  .clk, .rst_b, .ce, .init, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .instr, .result, .fp_error_ext, .irq_req, .nmi_req,
  .irq_take, .nmi_take, .protected_on, .paging_on, .walk_base
);
`default_nettype wire

// *** tb/test_fpgate_core.sv ***
// Purpose: Self-checking bench for the fault gating core
// Assumes: ce held high; inputs change by NBA at rising edges
// Notes:   Media state is not visible at the ports; the save and
//          restore round trip of the SIMD control word stands in
`timescale 1ns/10ps
`default_nettype none
module test_fpgate_core import fpgate_pkg::*; ;
  logic        clk, rst_b, ce, init, reg_wr, reg_rd, irq_req, nmi_req;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, walk_base;
  instr_t      instr;
  result_t     result;
  logic        fp_error_ext, irq_take, nmi_take, protected_on, paging_on;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;

  fpgate_core #(.MODEL_REGS(16)) dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .init(init), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr(instr), .result(result),
    .fp_error_ext(fp_error_ext), .irq_req(irq_req), .nmi_req(nmi_req),
    .irq_take(irq_take), .nmi_take(nmi_take),
    .protected_on(protected_on), .paging_on(paging_on),
    .walk_base(walk_base)
  );

  // Compare and count
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read; data stands only in the following cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", 64'(reg_rdata), 64'(e));
  endtask

  // One instruction; model index rides in the low data nibble
  task automatic ex(input instr_cls_t c, input logic [5:0] e,
                    input logic [63:0] d, input fault_t f);
    @(posedge clk);
    instr <= '{1'b1, c, e, d[3:0], d};
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
    chk("result_valid", 64'(result.valid), 64'h1);
    chk("fault", 64'(result.fault), 64'(f));
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    rd(OFS_CTRL0, 32'h0);
    rd(OFS_FLAGS, 32'h2);
    rd(OFS_MXCTL, 32'h1f80);
    rd(4'h9, 32'h0);
    wr(OFS_STATUS, 32'hf);
    rd(OFS_STATUS, 32'h0);
    ex(CLS_MODEL_RD, 6'h0, 64'h5, FLT_NONE);
    chk("model_data", result.data, 64'h0);
    $display("test reset done");
  endtask

  task automatic t_x87;
    wr(OFS_CTRL0, 32'ha);
    ex(CLS_FP_SYNC, 6'h0, 64'h0, FLT_DEV_UNAVAIL);
    wr(OFS_CTRL0, 32'h2);
    ex(CLS_FP_SYNC, 6'h0, 64'h0, FLT_NONE);
    wr(OFS_CTRL0, 32'h4);
    ex(CLS_X87, 6'h0, 64'h0, FLT_DEV_UNAVAIL);
    ex(CLS_MEDIA, 6'h0, 64'h0, FLT_INVALID_OP);
    ex(CLS_SIMD, 6'h0, 64'h0, FLT_INVALID_OP);
    ex(CLS_VEC_SAVE, 6'h0, 64'h0, FLT_DEV_UNAVAIL);
    ex(CLS_VEC_RESTORE, 6'h0, 64'h0, FLT_DEV_UNAVAIL);
    wr(OFS_CTRL0, 32'h20);
    wr(OFS_MXCTL, 32'h0);
    ex(CLS_X87, 6'h1, 64'h0, FLT_FP_PENDING);
    wr(OFS_MXCTL, 32'h1f80);
    ex(CLS_X87, 6'h1, 64'h0, FLT_NONE);
    wr(OFS_CTRL0, 32'h0);
    ex(CLS_MEDIA, 6'h0, 64'h0, FLT_NONE);
    wr(OFS_MXCTL, 32'h0);
    ex(CLS_X87, 6'h2, 64'h0, FLT_NONE);
    tick(1);
    chk("fp_error_ext", 64'(fp_error_ext), 64'h1);
    rd(OFS_STATUS, 32'h8);
    ex(CLS_FP_CLEAR, 6'h0, 64'h0, FLT_NONE);
    tick(1);
    chk("fp_error_ext", 64'(fp_error_ext), 64'h0);
    $display("test x87 done");
  endtask

  task automatic t_simd;
    ex(CLS_SIMD, 6'h0, 64'h0, FLT_INVALID_OP);
    wr(OFS_CTRL4, 32'h200);
    ex(CLS_SIMD, 6'h0, 64'h0, FLT_NONE);
    ex(CLS_SIMD, 6'h1, 64'h0, FLT_INVALID_OP);
    wr(OFS_CTRL4, 32'hffff_ffff);
    rd(OFS_CTRL4, 32'h600);
    ex(CLS_SIMD, 6'h4, 64'h0, FLT_SIMD_FP);
    rd(OFS_MXCTL, 32'h4);
    wr(OFS_MXCTL, 32'hffff_ffff);
    rd(OFS_MXCTL, 32'h1fbf);
    ex(CLS_SIMD, 6'h4, 64'h0, FLT_NONE);
    ex(CLS_VEC_SAVE, 6'h0, 64'h0, FLT_NONE);
    wr(OFS_MXCTL, 32'h1f80);
    ex(CLS_VEC_RESTORE, 6'h0, 64'h0, FLT_NONE);
    rd(OFS_MXCTL, 32'h1fbf);
    $display("test simd done");
  endtask

  task automatic t_model;
    ex(CLS_MODEL_WR, 6'h0, 64'h0123_4567_89ab_cde3, FLT_NONE);
    ex(CLS_MODEL_RD, 6'h0, 64'h3, FLT_NONE);
    chk("model_data", result.data, 64'h0123_4567_89ab_cde3);
    $display("test model done");
  endtask

  task automatic t_irq;
    @(posedge clk);
    irq_req <= 1'b1;
    nmi_req <= 1'b1;
    tick(2);
    chk("irq_take", 64'(irq_take), 64'h0);
    chk("nmi_take", 64'(nmi_take), 64'h1);
    wr(OFS_FLAGS, 32'hffff_ffff);
    tick(2);
    chk("irq_take", 64'(irq_take), 64'h1);
    rd(OFS_FLAGS, 32'h202);
    @(posedge clk);
    irq_req <= 1'b0;
    nmi_req <= 1'b0;
    tick(2);
    chk("take", {irq_take, nmi_take}, 64'h0);
    $display("test interrupts done");
  endtask

  task automatic t_mode;
    wr(OFS_CTRL0, 32'h8000_0001);
    tick(1);
    chk("modes", {protected_on, paging_on}, 64'h0);
    wr(OFS_VTP, 32'h1000);
    rd(OFS_STATUS, 32'h2);
    wr(OFS_GDP, 32'h2000);
    wr(OFS_CTRL0, 32'h1);
    tick(1);
    chk("modes", {protected_on, paging_on}, 64'h2);
    wr(OFS_TBASE, 32'h0003_4000);
    wr(OFS_CTRL0, 32'h8000_0001);
    tick(1);
    chk("modes", {protected_on, paging_on}, 64'h3);
    chk("walk_base", 64'(walk_base), 64'h3_4000);
    wr(OFS_MXCTL, 32'h1f81);
    @(posedge clk);
    init <= 1'b1;
    @(posedge clk);
    init <= 1'b0;
    tick(1);
    chk("modes", {protected_on, paging_on}, 64'h0);
    rd(OFS_MXCTL, 32'h1f81);
    rd(OFS_STATUS, 32'h0);
    ex(CLS_MODEL_RD, 6'h0, 64'h3, FLT_NONE);
    chk("model_data", result.data, 64'h0123_4567_89ab_cde3);
    $display("test modes done");
  endtask

  // Write and instruction at one edge: only the next sees it
  task automatic t_commit;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= OFS_CTRL0;
    reg_wdata <= 32'h4;
    instr <= '{1'b1, CLS_MEDIA, 6'h0, 4'h0, 64'h0};
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    chk("fault", 64'(result.fault), 64'(FLT_NONE));
    @(posedge clk);
    instr.valid <= 1'b0;
    #1;
    chk("fault", 64'(result.fault), 64'(FLT_INVALID_OP));
    wr(OFS_CTRL0, 32'h0);
    $display("test commit done");
  endtask

  // Free-running 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard: the whole run needs under two hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test;
    end
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    init = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    instr = '0;
    irq_req = 1'b0;
    nmi_req = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_x87;
    t_simd;
    t_model;
    t_irq;
    t_mode;
    t_commit;
    stop_test;
  end
endmodule
`default_nettype wire
